//--- hdl/acs_adc_sequencer.v
// Conversion sequencer with AXI4-Lite registers and SAR comparator interface
`include "acs_defines.vh"
module acs_adc_sequencer (
   input wire CLK,
   input wire RST,
   input wire [3:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   output wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   output wire S_AXI_WREADY,
   output reg [1:0] S_AXI_BRESP,
   output reg S_AXI_BVALID,
   input wire S_AXI_BREADY,
   input wire [3:0] S_AXI_ARADDR,
   input wire S_AXI_ARVALID,
   output wire S_AXI_ARREADY,
   output reg [31:0] S_AXI_RDATA,
   output reg [1:0] S_AXI_RRESP,
   output reg S_AXI_RVALID,
   input wire S_AXI_RREADY,
   output reg [2:0] CHANNEL_SEL,
   output reg SAMPLE_EN,
   output reg [7:0] TRIAL_CODE,
   input wire COMPARE_HIGH,
   output reg [3:0] INTERNAL_UPPER_REFERENCE,
   output reg [3:0] INTERNAL_LOWER_REFERENCE
);
   // ****************************************
   // Register state
   // ****************************************
   reg [2:0] chan;
   reg cont;
   reg busy;
   reg [7:0] result;
   reg [7:0] refprog;
   reg [4:0] cyc;
   reg [7:0] sar;
   reg [3:0] bitpos;
   reg [3:0] aw_addr;
   reg aw_held;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   reg w_held;
   wire wr_go;
   wire [3:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire wr_ctrl;
   wire wr_res;
   wire wr_ref;
   wire load;
   // ****************************************
   // Write channel: address and data in either order
   // ****************************************
   // Hold each half until the other arrives; stall both while a response is pending
   assign S_AXI_AWREADY = !aw_held && !S_AXI_BVALID;
   assign S_AXI_WREADY = !w_held && !S_AXI_BVALID;
   assign wr_addr = aw_held ? aw_addr : S_AXI_AWADDR;
   assign wr_data = w_held ? w_data : S_AXI_WDATA;
   assign wr_strb = w_held ? w_strb : S_AXI_WSTRB;
   assign wr_go = (aw_held || (S_AXI_AWVALID && S_AXI_AWREADY)) &&
                  (w_held || (S_AXI_WVALID && S_AXI_WREADY));
   assign wr_ctrl = wr_go && wr_addr == `ACS_CTRL_OFS && wr_strb[0];
   assign wr_res = wr_go && wr_addr == `ACS_RESULT_OFS && wr_strb[0];
   // Any byte-0 write to the reference register starts a conversion
   assign wr_ref = wr_go && wr_addr == `ACS_REFPROG_OFS && wr_strb[0];
   assign load = busy && cyc == `ACS_CONV_CYC;

   always @(posedge CLK) begin
      if (RST) begin
         aw_held <= 1'b0;
         aw_addr <= 4'h0;
         w_held <= 1'b0;
         w_data <= 32'h0;
         w_strb <= 4'h0;
         S_AXI_BVALID <= 1'b0;
         S_AXI_BRESP <= `ACS_RESP_OKAY;
      end else begin
         if (wr_go) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP <= (wr_addr == `ACS_CTRL_OFS || wr_addr == `ACS_RESULT_OFS ||
                            wr_addr == `ACS_REFPROG_OFS) ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
         end else begin
            if (S_AXI_AWVALID && S_AXI_AWREADY) begin
               aw_held <= 1'b1;
               aw_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY) begin
               w_held <= 1'b1;
               w_data <= S_AXI_WDATA;
               w_strb <= S_AXI_WSTRB;
            end
         end
         if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
         end
      end
   end

   // ****************************************
   // Read channel
   // ****************************************
   assign S_AXI_ARREADY = !S_AXI_RVALID;
   always @(posedge CLK) begin
      if (RST) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA <= 32'h0;
         S_AXI_RRESP <= `ACS_RESP_OKAY;
      end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         S_AXI_RVALID <= 1'b1;
         S_AXI_RRESP <= `ACS_RESP_OKAY;
         case (S_AXI_ARADDR)
            `ACS_CTRL_OFS: S_AXI_RDATA <= {27'h0, busy, cont, chan};
            `ACS_RESULT_OFS: S_AXI_RDATA <= {24'h0, result};
            `ACS_REFPROG_OFS: S_AXI_RDATA <= {24'h0, refprog};
            default: begin
               S_AXI_RDATA <= 32'h0;
               S_AXI_RRESP <= `ACS_RESP_SLVERR;
            end
         endcase
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
         S_AXI_RVALID <= 1'b0;
      end
   end

   // ****************************************
   // Software registers
   // ****************************************
   always @(posedge CLK) begin
      if (RST) begin
         chan <= 3'h0;
         cont <= 1'b0;
         refprog <= `ACS_REFPROG_RST;
         result <= `ACS_RESULT_RST;
      end else begin
         if (wr_ctrl) begin
            chan <= wr_data[`ACS_CHAN_MSB:`ACS_CHAN_LSB];
            cont <= wr_data[`ACS_CONT_BIT];
         end
         if (wr_ref) begin
            refprog <= wr_data[7:0];
         end
         // Converted value wins over a write in the same cycle
         if (load) begin
            result <= {sar[7:1], COMPARE_HIGH};
         end else if (wr_res) begin
            result <= wr_data[7:0];
         end
      end
   end

   // ****************************************
   // Reference levels
   // ****************************************
   // High nibble lowers the top, low nibble raises the bottom; zero means external refs.
   // Non-zero codes only steer levels; conversion length stays fifteen cycles.
   always @(posedge CLK) begin
      if (RST) begin
         INTERNAL_UPPER_REFERENCE <= 4'h0;
         INTERNAL_LOWER_REFERENCE <= 4'h0;
      end else begin
         INTERNAL_UPPER_REFERENCE <= refprog[7:4];
         INTERNAL_LOWER_REFERENCE <= refprog[3:0];
      end
   end

   // ****************************************
   // Conversion sequencer
   // ****************************************
   // Cycle 0 is the write; cycles 1-5 sample, 6-13 resolve, 15 loads the result
   always @(posedge CLK) begin
      if (RST) begin
         busy <= 1'b0;
         cyc <= 5'd0;
         sar <= 8'h00;
         bitpos <= 4'd7;
         SAMPLE_EN <= 1'b0;
         CHANNEL_SEL <= 3'h0;
         TRIAL_CODE <= 8'h00;
      end else if (wr_ref || (load && cont)) begin
         // Restart also aborts a running conversion
         busy <= 1'b1;
         cyc <= 5'd1;
         sar <= 8'h00;
         bitpos <= 4'd7;
         SAMPLE_EN <= 1'b1;
         CHANNEL_SEL <= chan;
         TRIAL_CODE <= 8'h80;
      end else if (busy) begin
         cyc <= cyc + 5'd1;
         SAMPLE_EN <= (cyc < `ACS_SAMPLE_CYC);
         if (cyc >= `ACS_SAMPLE_CYC + 5'd1 && bitpos != 4'hf) begin
            // One bit per cycle, MSB first; last bit is taken at load
            sar[bitpos[2:0]] <= COMPARE_HIGH;
            bitpos <= bitpos - 4'd1;
            TRIAL_CODE <= (bitpos == 4'd0) ? TRIAL_CODE :
               ((TRIAL_CODE & ~(8'h01 << bitpos[2:0])) |
               ({7'h0, COMPARE_HIGH} << bitpos[2:0]) | (8'h01 << (bitpos[2:0] - 3'd1)));
         end
         if (load) begin
            busy <= 1'b0;
            cyc <= 5'd0;
            SAMPLE_EN <= 1'b0;
         end
      end
   end
endmodule // acs_adc_sequencer

//--- hdl/acs_defines.vh
// Constants and register map of the conversion sequencer
`ifndef ACS_DEFINES_VH
`define ACS_DEFINES_VH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define ACS_CTRL_OFS 4'h0
`define ACS_RESULT_OFS 4'h4
`define ACS_REFPROG_OFS 4'h8
// ****************************************
// Control register fields
// ****************************************
`define ACS_CHAN_LSB 0
`define ACS_CHAN_MSB 2
`define ACS_CONT_BIT 3
`define ACS_BUSY_BIT 4
// ****************************************
// Reset values and timing
// ****************************************
`define ACS_CTRL_RST 4'h0
`define ACS_RESULT_RST 8'h00
`define ACS_REFPROG_RST 8'h00
`define ACS_SAMPLE_CYC 5'd5
`define ACS_CONV_CYC 5'd15
`define ACS_RESP_OKAY 2'b00
`define ACS_RESP_SLVERR 2'b10
`endif

//--- verif/acs_sva.sv
// Port assertions for the conversion sequencer
`include "acs_defines.vh"
module acs_sva (
   input wire CLK,
   input wire RST,
   input wire [3:0] S_AXI_AWADDR,
   input wire S_AXI_AWVALID,
   input wire S_AXI_AWREADY,
   input wire [31:0] S_AXI_WDATA,
   input wire [3:0] S_AXI_WSTRB,
   input wire S_AXI_WVALID,
   input wire S_AXI_WREADY,
   input wire S_AXI_BVALID,
   input wire S_AXI_ARVALID,
   input wire S_AXI_ARREADY,
   input wire S_AXI_RVALID,
   input wire [2:0] CHANNEL_SEL,
   input wire SAMPLE_EN,
   input wire [3:0] INTERNAL_UPPER_REFERENCE,
   input wire [3:0] INTERNAL_LOWER_REFERENCE
);
   // One clock domain
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // Same-edge handshake only, as the bench offers both halves together
   wire wr = S_AXI_AWVALID & S_AXI_AWREADY & S_AXI_WVALID & S_AXI_WREADY;
   wire go = wr & S_AXI_WSTRB[0] & (S_AXI_AWADDR == `ACS_REFPROG_OFS);
   // Reference pins lag the register by one flop, so they settle two edges after the write
   wire [7:0] rf = {INTERNAL_UPPER_REFERENCE, INTERNAL_LOWER_REFERENCE};
   a_start_sample: assert property (go |=> SAMPLE_EN)
      else $error("no sampling");
   a_sample_five: assert property (go ##1 !go [*5] |-> SAMPLE_EN ##1 !SAMPLE_EN)
      else $error("bad sample length");
   a_chan_latch: assert property ($changed(CHANNEL_SEL) |-> $past(go))
      else $error("channel moved");
   a_ref_load: assert property (go |-> ##2 rf == $past(S_AXI_WDATA[7:0], 2))
      else $error("reference not loaded");
   a_ref_hold: assert property ($changed(rf) |-> $past(go, 2))
      else $error("reference moved");
   a_write_answer: assert property (wr |=> S_AXI_BVALID)
      else $error("no write answer");
   a_write_refuse: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("write taken early");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
      else $error("no read answer");
endmodule // acs_sva

//--- verif/acs_adc_sequencer_tb_top.sv
// Self-checking bench for the conversion sequencer
module acs_adc_sequencer_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic CLK = 0, RST = 1, S_AXI_AWVALID = 0, S_AXI_WVALID = 0, S_AXI_BREADY = 1;
   logic S_AXI_ARVALID = 0, S_AXI_RREADY = 1, S_AXI_AWREADY, S_AXI_WREADY;
   logic S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID, SAMPLE_EN;
   logic [3:0] S_AXI_AWADDR = 0, S_AXI_ARADDR = 0, S_AXI_WSTRB = 0;
   logic [3:0] INTERNAL_UPPER_REFERENCE, INTERNAL_LOWER_REFERENCE;
   logic [31:0] S_AXI_WDATA = 0, S_AXI_RDATA, seed = 32'h67e1;
   logic [1:0] S_AXI_BRESP, S_AXI_RRESP, bq[$];
   logic [7:0] TRIAL_CODE, ana = 8'h00;
   logic [2:0] CHANNEL_SEL;
   logic [33:0] rq[$];
   int num_errors = 0, n_checks = 0;
   // Ideal comparator, so any slip in the search shows in the result
   wire COMPARE_HIGH = ana >= TRIAL_CODE;
   // Free-running clock
   always #5 CLK = ~CLK;
   acs_adc_sequencer acs_adc_sequencer_inst (.*);
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Write halves offered together and held until taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
      bq.push_back(r);
      S_AXI_AWADDR <= a;
      S_AXI_WDATA <= d;
      S_AXI_WSTRB <= 4'hf;
      S_AXI_AWVALID <= 1;
      S_AXI_WVALID <= 1;
      do @(posedge CLK); while (!(S_AXI_AWREADY && S_AXI_WREADY));
      S_AXI_AWVALID <= 0;
      S_AXI_WVALID <= 0;
      do @(posedge CLK); while (!S_AXI_BVALID);
   endtask
   task automatic rd(input logic [3:0] a, input logic [33:0] e);
      rq.push_back(e);
      S_AXI_ARADDR <= a;
      S_AXI_ARVALID <= 1;
      do @(posedge CLK); while (!S_AXI_ARREADY);
      S_AXI_ARVALID <= 0;
      do @(posedge CLK); while (!S_AXI_RVALID);
   endtask
   task automatic cmp_rd(input logic [33:0] e, g);
      n_checks++;
      if (g !== e) num_errors++;
      if (g !== e) $display("unexpected read %0t %h %h", $time, g, e);
   endtask
   task automatic cmp_b(input logic [1:0] e, g);
      n_checks++;
      if (g !== e) num_errors++;
      if (g !== e) $display("unexpected resp %0t %h %h", $time, g, e);
   endtask
   // Each answer takes the oldest note; readies are always high
   always @(posedge CLK) begin
      if (S_AXI_RVALID) cmp_rd(rq.pop_front(), {S_AXI_RRESP, S_AXI_RDATA});
      if (S_AXI_BVALID) cmp_b(bq.pop_front(), S_AXI_BRESP);
   end
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   // Hang guard, well above the few microseconds needed
   initial begin
      #100us;
      num_errors++;
      conclude();
   end
   // Result reads at 14 and 16 edges after the start write bracket the load
   initial begin
      logic [31:0] v;
      repeat (5) @(posedge CLK);
      RST <= 0;
      @(posedge CLK);
      rd(4'h0, 34'h0);
      wr(4'hc, 32'h1, 2'h2);
      rd(4'hc, 34'h200000000);
      for (int c = 0; c < 8; c++) begin
         v = rnd();
         ana <= v[7:0];
         wr(4'h0, c);
         wr(4'h4, 32'h5a);
         wr(4'h8, c * 17);
         rd(4'h0, 34'h10 + c);
         repeat (10) @(posedge CLK);
         rd(4'h4, 34'h5a);
         rd(4'h4, v[7:0]);
         rd(4'h0, c);
      end
      wr(4'h8, 32'h0);
      repeat (6) @(posedge CLK);
      ana <= 8'hc3;
      wr(4'h8, 32'h0);
      repeat (14) @(posedge CLK);
      rd(4'h4, 34'hc3);
      wr(4'h0, 32'hd);
      wr(4'h8, 32'h0);
      repeat (40) @(posedge CLK);
      rd(4'h0, 34'h1d);
      ana <= 8'h77;
      repeat (40) @(posedge CLK);
      rd(4'h4, 34'h77);
      wr(4'h0, 32'h5);
      repeat (20) @(posedge CLK);
      rd(4'h0, 34'h5);
      conclude();
   end
endmodule // acs_adc_sequencer_tb_top
bind acs_adc_sequencer acs_sva acs_sva_inst (.*);
